/* File: verilog/timer16_consts.svh */
`ifndef TIMER16_CONSTS_SVH
`define TIMER16_CONSTS_SVH

// register byte addresses on the AXI4-Lite bus
`define TIMER_CONTROL_REG_ADDR 8'h00
`define COUNT_REGISTER_ADDR 8'h04

// control field positions
`define CTRL_TIMER_ON_BIT 15
`define CTRL_STOP_IN_IDLE_BIT 13
`define CTRL_GATED_ACC_BIT 6
`define CTRL_PRESCALE_HI_BIT 5
`define CTRL_PRESCALE_LO_BIT 4
`define CTRL_EXT_SYNC_BIT 2
`define CTRL_CLOCK_SOURCE_BIT 1

// writable bits of the control register; others read as zero
`define CTRL_WRITE_MASK 16'hA076

// reset values
`define CTRL_RESET_VALUE 16'h0000
`define COUNT_RESET_VALUE 16'h0000

// prescaler terminal counts for 1:1, 1:8, 1:64 and 1:256
`define PRESCALE_TERM_1 8'h00
`define PRESCALE_TERM_8 8'h07
`define PRESCALE_TERM_64 8'h3F
`define PRESCALE_TERM_256 8'hFF

// bus responses
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

/* File: verilog/timer16_pkg.sv */
`default_nettype none

package timer16_pkg;

    // operating mode decoded from the control bits
    typedef enum logic [1:0] {
        mode_timer,
        mode_gated_timer,
        mode_sync_counter,
        mode_async_counter
    } timer_mode_t;

    // one buffered register write: address, data and byte enables
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } reg_write_t;

endpackage

`default_nettype wire

/* File: verilog/timer16.sv */
// What this block does
// - sixteen-bit free-running count register
// - async counter mode counts pin without resync
// - sync mode resyncs prescaler output, not pin
// - timer modes count instruction clock ticks
// - counter modes count external pin edges
// - source bit1, sync bit2, gate bit6
// - mode decoded from source, gate, sync
// - on bit 15 starts and stops counting
// - prescaler divides by 1, 8, 64, 256
// - stop-in-idle halts counting during idle
// - count writes ignored in running sync mode
`timescale 1ns/100ps
`default_nettype none
`include "timer16_consts.svh"

module timer16
    import timer16_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // external count clock and gate pin, device idle state
    input wire logic timer_ext_clock_pin,
    input wire logic device_idle,
    // current count
    output logic [15:0] count_value
);

    // merge a 16-bit register with the two low byte lanes of a write
    function automatic logic [15:0] merge_lanes(input logic [15:0] old_value, input logic [31:0] data,
                                                input logic [3:0] strb);
        logic [15:0] result;
        result = old_value;
        if (strb[0])
        begin
            result[7:0] = data[7:0];
        end
        if (strb[1])
        begin
            result[15:8] = data[15:8];
        end
        return result;
    endfunction

    // decode the operating mode from the control register
    function automatic timer_mode_t decode_mode(input logic [15:0] ctrl);
        timer_mode_t mode;
        mode = mode_timer;
        if (ctrl[`CTRL_CLOCK_SOURCE_BIT])
        begin
            mode = ctrl[`CTRL_EXT_SYNC_BIT] ? mode_sync_counter : mode_async_counter;
        end
        else
        begin
            mode = ctrl[`CTRL_GATED_ACC_BIT] ? mode_gated_timer : mode_timer;
        end
        return mode;
    endfunction

    // terminal count of the prescaler for a select code
    function automatic logic [7:0] prescale_term(input logic [1:0] sel);
        logic [7:0] term;
        case (sel)
            2'h0: term = `PRESCALE_TERM_1;
            2'h1: term = `PRESCALE_TERM_8;
            2'h2: term = `PRESCALE_TERM_64;
            default: term = `PRESCALE_TERM_256;
        endcase
        return term;
    endfunction

    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic [15:0] timer_control_reg;
    logic [15:0] next_timer_control_reg;
    logic [15:0] count_register;
    logic [15:0] next_count_register;
    logic [7:0] prescale_count;
    logic [7:0] next_prescale_count;
    logic prescale_resync;
    logic next_prescale_resync;
    logic aw_held;
    logic next_aw_held;
    logic w_held;
    logic next_w_held;
    reg_write_t wr_req;
    reg_write_t next_wr_req;
    logic bvalid;
    logic next_bvalid;
    logic [1:0] bresp;
    logic [1:0] next_bresp;
    logic rvalid;
    logic next_rvalid;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [1:0] rresp;
    logic [1:0] next_rresp;
    timer_mode_t mode;
    logic running;
    logic ext_rise;
    logic source_tick;
    logic prescale_tick;
    logic count_tick;
    logic commit;
    logic count_write_blocked;

    // the pin belongs to no clock domain: two flops before anything looks at it
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end
        else
        begin
            pin_meta <= timer_ext_clock_pin;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // mode, run state and the tick that feeds the prescaler
    always_comb
    begin
        mode = decode_mode(timer_control_reg);
        running = timer_control_reg[`CTRL_TIMER_ON_BIT]
                  && !(timer_control_reg[`CTRL_STOP_IN_IDLE_BIT] && device_idle);
        ext_rise = pin_sync && !pin_prev; // counts on the rising edge of the pin
        case (mode)
            mode_timer: source_tick = 1'b1;
            mode_gated_timer: source_tick = pin_sync;
            mode_sync_counter: source_tick = ext_rise;
            mode_async_counter: source_tick = ext_rise;
            default: source_tick = 1'b0;
        endcase
        // at or past the terminal count, so a smaller ratio chosen mid-count does not wrap through 256 first
        prescale_tick = running && source_tick
                        && (prescale_count
                            >= prescale_term(timer_control_reg[`CTRL_PRESCALE_HI_BIT:`CTRL_PRESCALE_LO_BIT]));
        // the resync stage sits after the prescaler, so only divided ticks are delayed
        count_tick = (mode == mode_sync_counter) ? (prescale_resync && running) : prescale_tick;
    end

    // prescaler and its resync stage
    always_comb
    begin
        next_prescale_count = prescale_count;
        if (!running)
        begin
            next_prescale_count = 8'h00; // a stopped timer restarts with a clean divide
        end
        else if (prescale_tick)
        begin
            next_prescale_count = 8'h00;
        end
        else if (source_tick)
        begin
            next_prescale_count = prescale_count + 8'h01;
        end
        next_prescale_resync = prescale_tick && (mode == mode_sync_counter);
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prescale_count <= 8'h00;
            prescale_resync <= 1'b0;
        end
        else
        begin
            prescale_count <= next_prescale_count;
            prescale_resync <= next_prescale_resync;
        end
    end

    // write channels: address and data are taken in either order, committed together
    always_comb
    begin
        s_axi_awready = !aw_held && !bvalid;
        s_axi_wready = !w_held && !bvalid;
        commit = aw_held && w_held && !bvalid;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_wr_req = wr_req;
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_wr_req.addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_wr_req.data = s_axi_wdata;
            next_wr_req.strb = s_axi_wstrb;
        end
        if (commit)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            if (wr_req.addr == `TIMER_CONTROL_REG_ADDR || wr_req.addr == `COUNT_REGISTER_ADDR)
            begin
                next_bresp = `AXI_RESP_OKAY;
            end
            else
            begin
                next_bresp = `AXI_RESP_SLVERR; // unmapped address, nothing stored
            end
        end
        else if (bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_req <= '0;
            bvalid <= 1'b0;
            bresp <= `AXI_RESP_OKAY;
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            wr_req <= next_wr_req;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
        end
    end

    // control and count registers; a software write outranks a tick in the same cycle
    always_comb
    begin
        count_write_blocked = (mode == mode_sync_counter) && timer_control_reg[`CTRL_TIMER_ON_BIT];
        next_timer_control_reg = timer_control_reg;
        next_count_register = count_register;
        if (count_tick)
        begin
            next_count_register = count_register + 16'h0001; // wraps freely past FFFF
        end
        if (commit && wr_req.addr == `TIMER_CONTROL_REG_ADDR)
        begin
            next_timer_control_reg = merge_lanes(timer_control_reg, wr_req.data, wr_req.strb)
                                     & `CTRL_WRITE_MASK;
        end
        if (commit && wr_req.addr == `COUNT_REGISTER_ADDR && !count_write_blocked)
        begin
            next_count_register = merge_lanes(count_register, wr_req.data, wr_req.strb);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            timer_control_reg <= `CTRL_RESET_VALUE;
            count_register <= `COUNT_RESET_VALUE;
        end
        else
        begin
            timer_control_reg <= next_timer_control_reg;
            count_register <= next_count_register;
        end
    end

    // read channel: one read at a time, data registered with the valid
    always_comb
    begin
        s_axi_arready = !rvalid;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = `AXI_RESP_OKAY;
            case (s_axi_araddr)
                `TIMER_CONTROL_REG_ADDR: next_rdata = {16'h0000, timer_control_reg};
                `COUNT_REGISTER_ADDR: next_rdata = {16'h0000, count_register};
                default:
                begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = `AXI_RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `AXI_RESP_OKAY;
        end
        else
        begin
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // outputs
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
    assign count_value = count_register;

endmodule

`default_nettype wire

/* File: bench/timer16_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module timer16_checker (
    // bus handshakes
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // count
    input wire logic [15:0] count_value
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // both write channels taken at one edge
    sequence both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    write_answer_a: assert property (both_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not two edges after take");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write response not released");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    // outside a register write the count only steps up by one, wrapping
    count_step_a: assert property ($changed(count_value) && !$rose(s_axi_bvalid)
        |-> count_value == $past(count_value) + 16'h0001)
        else $error("count moved by other than one");
endmodule
`default_nettype wire

/* File: bench/pin_source.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_source #(parameter int HALF_NS = 250) (
    // command from the bench
    input wire logic run,
    input wire logic level,
    // count clock pin
    output var logic pin
);
    // toggles only while running, otherwise stands at the commanded level;
    // the phase offset keeps pin edges clear of both clock edges, so no sampling race
    initial
    begin
        pin = 1'b0;
        #25;
        forever
        begin
            #(HALF_NS);
            pin = run ? !pin : level;
        end
    end
endmodule
`default_nettype wire

/* File: bench/timer16_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "timer16_consts.svh"
module timer16_tb;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic device_idle = 1'b0, run = 1'b0, level = 1'b0, timer_ext_clock_pin;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] count_value, lfsr = 16'h0023;
    logic [33:0] expq[$];
    int errors = 0, n_tests = 0, p;
    int div[4] = '{1, 8, 64, 256};
    timer16 timer16_inst (.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .timer_ext_clock_pin, .device_idle, .count_value);
    pin_source pin_source_inst (.run, .level, .pin(timer_ext_clock_pin));
    always #50 sys_clk = !sys_clk;
    task chk(input string what, input logic [33:0] exp, input logic [33:0] got);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // handshakes are judged at the falling edge, acted on at the next rising edge
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ta, tw, tb;
        logic [1:0] r;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge sys_clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge sys_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!tb);
        s_axi_bready <= 1'b0;
        chk("bresp", er, r);
        // one idle edge so a following call never reassigns a strobe in this time step
        @(posedge sys_clk);
    endtask
    task rd(input logic [7:0] a, input logic [33:0] e);
        bit ta, tr;
        expq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge sys_clk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid && s_axi_rready;
            @(posedge sys_clk);
            if (ta) s_axi_arvalid <= 1'b0;
        end while (!tr);
        s_axi_rready <= 1'b0;
        @(posedge sys_clk);
    endtask
    // the read monitor takes the oldest note for each returned word
    always @(negedge sys_clk)
        if (s_axi_rvalid && s_axi_rready) chk("read", expq.pop_front(), {s_axi_rresp, s_axi_rdata});
    // cycles between two count steps; first step skipped since its phase is unknown
    task period(input int n);
        logic [15:0] c;
        int k;
        @(negedge sys_clk);
        c = count_value;
        for (k = 0; k < 900 && count_value === c; k++) @(negedge sys_clk);
        c = count_value;
        for (k = 1; k < 900; k++)
        begin
            @(negedge sys_clk);
            if (count_value !== c) break;
        end
        chk("period", n, k);
        @(posedge sys_clk);
    endtask
    // count sampled away from the clock edge that launches it
    task frozen;
        logic [15:0] c;
        @(negedge sys_clk);
        c = count_value;
        repeat (40) @(negedge sys_clk);
        chk("frozen", c, count_value);
        @(posedge sys_clk);
    endtask
    // clock edges from a pin rise to the count step: the resync stage adds one in sync mode
    task latency(input int n);
        logic [15:0] c;
        int k;
        @(posedge timer_ext_clock_pin);
        c = count_value;
        for (k = 1; k < 20; k++)
        begin
            @(posedge sys_clk);
            @(negedge sys_clk);
            if (count_value !== c) break;
        end
        chk("latency", n, k);
        @(posedge sys_clk);
    endtask
    function logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        rd(`TIMER_CONTROL_REG_ADDR, 34'h0);
        rd(`COUNT_REGISTER_ADDR, 34'h0);
        wr(8'h08, 32'hFFFF, 2'h2);
        rd(8'h08, {2'h2, 32'h0});
        wr(`TIMER_CONTROL_REG_ADDR, 32'hFFFFFFFF, 2'h0);
        rd(`TIMER_CONTROL_REG_ADDR, {2'h0, 32'h0000A076});
        $display("test registers done");
        for (p = 0; p < 4; p++)
        begin
            wr(`TIMER_CONTROL_REG_ADDR, 32'h8000 | (p << 4), 2'h0);
            period(div[p]);
        end
        device_idle <= 1'b1;
        wr(`TIMER_CONTROL_REG_ADDR, 32'hA000, 2'h0);
        frozen;
        wr(`TIMER_CONTROL_REG_ADDR, 32'h8000, 2'h0);
        period(1);
        device_idle <= 1'b0;
        wr(`TIMER_CONTROL_REG_ADDR, 32'h8040, 2'h0);
        frozen;
        level <= 1'b1;
        period(1);
        level <= 1'b0;
        $display("test timer modes done");
        wr(`TIMER_CONTROL_REG_ADDR, 32'h0, 2'h0);
        frozen;
        lfsr = next_rand(lfsr);
        wr(`COUNT_REGISTER_ADDR, {16'h0, lfsr}, 2'h0);
        wr(`TIMER_CONTROL_REG_ADDR, 32'h8006, 2'h0);
        wr(`COUNT_REGISTER_ADDR, 32'h1234, 2'h0);
        rd(`COUNT_REGISTER_ADDR, {18'h0, lfsr});
        run <= 1'b1;
        period(5);
        latency(4);
        wr(`TIMER_CONTROL_REG_ADDR, 32'h8016, 2'h0);
        period(40);
        wr(`TIMER_CONTROL_REG_ADDR, 32'h8002, 2'h0);
        period(5);
        latency(3);
        run <= 1'b0;
        $display("test counter modes done");
        end_of_test;
    end
    // watchdog well beyond the expected thousand or so cycles
    initial
    begin
        #2000000;
        errors++;
        end_of_test;
    end
endmodule
bind timer16 timer16_checker timer16_checker_inst (.sys_clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .count_value);
`default_nettype wire
